// ---- rtc_map.svh ----
// register addresses, bit positions, bcd limits and timing counts of the clock core
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// register addresses on the internal register port
`define RTC_A_CTRL1 8'h00
`define RTC_A_CTRL2 8'h01
`define RTC_A_SEC 8'h02
`define RTC_A_MIN 8'h03
`define RTC_A_HOUR 8'h04
`define RTC_A_ALM_MIN 8'h09
`define RTC_A_ALM_WDAY 8'h0c
`define RTC_A_SQW 8'h0d
`define RTC_A_TCTRL 8'h0e
`define RTC_A_TVAL 8'h0f
// bit positions
`define RTC_B_TEST 7
`define RTC_B_STOP 5
`define RTC_B_POR_OVERRIDE_PERMIT 3
`define RTC_B_TP 4
`define RTC_B_AF 3
`define RTC_B_TF 2
`define RTC_B_AIE 1
`define RTC_B_TIE 0
`define RTC_B_TOP 7
// bcd limits
`define RTC_BCD_59 7'h59
`define RTC_BCD_23 7'h23
`define RTC_BCD_9 4'h9
// divider chain: 512 crystal ticks per 64 Hz tick, second at prescaler 31 -> 32
`define RTC_DIV_MAX 9'h1ff
`define RTC_DIV_4K_MAX 3'h7
`define RTC_PRE_HALF 6'h1f
// low pulse widths in crystal ticks (1/8192, 1/4096, 1/128, 1/64 s)
`define RTC_PW_8192 10'h004
`define RTC_PW_4096 10'h008
`define RTC_PW_128 10'h100
`define RTC_PW_64 10'h200
// oscillator watchdog: time without a crystal edge before the fail flag sets
`define RTC_OSC_FAIL_US 1000
`define RTC_CLK_MHZ 40
`endif

// ---- rtc_pkg.sv ----
// types shared by the clock core
package rtc_pkg;
    // timer source select encoding, in field order
    typedef enum logic [1:0] {SRC_4096, SRC_64, SRC_1, SRC_60} rtc_src_t;
    // one access on the register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtc_bus_req_t;
    // software control bits
    typedef struct packed {
        logic test;
        logic stop;
        logic por_override_permit;
        logic tp;
        logic alarm_irq_enable;
        logic countdown_irq_enable;
        logic square_out_enable;
        logic [1:0] rs;
        logic te;
        logic [1:0] td;
    } rtc_ctrl_t;
endpackage

// ---- rtc_core.sv ----
// timekeeping, countdown timer, alarm flag, interrupt and square-wave logic of the clock
`include "rtc_map.svh"

module rtc_core #(
    // cycles without a crystal edge before the fail flag sets
    parameter int OSC_FAIL_CYCLES = `RTC_OSC_FAIL_US * `RTC_CLK_MHZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port from the serial interface logic
    input wire rtc_pkg::rtc_bus_req_t bus_req,
    output logic [7:0] rd_data_q,
    // crystal level, asynchronous
    input wire logic xtal_i,
    // calendar digits kept outside this block
    input wire logic [5:0] cal_date,
    input wire logic [2:0] cal_weekday,
    output logic day_carry_q,
    // open-drain interrupt pin, active low
    output logic int_n_o_q,
    output logic int_n_oe_q,
    // square-wave pin, two-way
    input wire logic sq_i,
    output logic sq_o_q,
    output logic sq_oe_q,
    // power-on reset override permission
    output logic por_override_permit_q
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // bcd increment with wrap at top; msb of the result is the wrap carry
    function automatic logic [7:0] bcd_inc(input logic [6:0] v, input logic [6:0] top);
        logic [7:0] r;
        r = {1'b0, v};
        if (v == top) begin
            r = 8'h80;
        end else if (v[3:0] == `RTC_BCD_9) begin
            r = {1'b0, 3'(v[6:4] + 3'h1), 4'h0};
        end else begin
            r = {1'b0, 7'(v + 7'h01)};
        end
        return r;
    endfunction

    // register write strobe for one address
    function automatic logic wr_hit(input rtc_pkg::rtc_bus_req_t q, input logic [7:0] a);
        return q.wr && (q.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [2:0] xs_q; // crystal sampler, [0] feeds [1] only
    logic [2:0] ss_q; // square pin sampler, [0] feeds [1] only
    logic x_lvl_q; // accepted crystal level
    logic s_lvl_q; // accepted square pin level
    wire x_agree = (xs_q[1] == xs_q[2]);
    wire s_agree = (ss_q[1] == ss_q[2]);
    wire x_rise = x_agree && xs_q[2] && !x_lvl_q;
    wire s_rise = s_agree && ss_q[2] && !s_lvl_q;

    // three-stage sampling; a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xs_q <= 3'h0;
            ss_q <= 3'h0;
            x_lvl_q <= 1'b0;
            s_lvl_q <= 1'b0;
        end else begin
            xs_q <= {xs_q[1:0], xtal_i};
            ss_q <= {ss_q[1:0], sq_i};
            x_lvl_q <= x_agree ? xs_q[2] : x_lvl_q;
            s_lvl_q <= s_agree ? ss_q[2] : s_lvl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    rtc_pkg::rtc_ctrl_t ctrl_q;
    rtc_pkg::rtc_ctrl_t ctrl_d;
    rtc_pkg::rtc_bus_req_t rq;
    assign rq = bus_req;
    wire w_c1 = wr_hit(rq, `RTC_A_CTRL1);
    wire w_c2 = wr_hit(rq, `RTC_A_CTRL2);
    wire w_sqw = wr_hit(rq, `RTC_A_SQW);
    wire w_tc = wr_hit(rq, `RTC_A_TCTRL);
    wire w_tv = wr_hit(rq, `RTC_A_TVAL);
    wire w_sec = wr_hit(rq, `RTC_A_SEC);
    wire w_min = wr_hit(rq, `RTC_A_MIN);
    wire w_hr = wr_hit(rq, `RTC_A_HOUR);

    // next control value: each field loads from its own register write
    always_comb begin
        ctrl_d = ctrl_q;
        if (w_c1) begin
            ctrl_d.test = rq.wdata[`RTC_B_TEST];
            ctrl_d.stop = rq.wdata[`RTC_B_STOP];
            ctrl_d.por_override_permit = rq.wdata[`RTC_B_POR_OVERRIDE_PERMIT];
        end
        if (w_c2) begin
            ctrl_d.tp = rq.wdata[`RTC_B_TP];
            ctrl_d.alarm_irq_enable = rq.wdata[`RTC_B_AIE];
            ctrl_d.countdown_irq_enable = rq.wdata[`RTC_B_TIE];
        end
        if (w_sqw) begin
            ctrl_d.square_out_enable = rq.wdata[`RTC_B_TOP];
            ctrl_d.rs = rq.wdata[1:0];
        end
        if (w_tc) begin
            ctrl_d.te = rq.wdata[`RTC_B_TOP];
            ctrl_d.td = rq.wdata[1:0];
        end
    end

    // control reset: square enable, source 11 and override permit come up set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '{test: 1'b0, stop: 1'b0, por_override_permit: 1'b1, tp: 1'b0, alarm_irq_enable: 1'b0,
                        countdown_irq_enable: 1'b0, square_out_enable: 1'b1, rs: 2'h0, te: 1'b0, td: 2'h3};
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // divider chain and prescaler

    logic [8:0] div_q; // crystal ticks within one 64 Hz period
    logic [5:0] pre_q; // 64 Hz ticks within one second
    // external edges replace the internal 64 Hz tick in test mode
    wire tick64 = ctrl_q.test ? s_rise : (x_rise && (div_q == `RTC_DIV_MAX));
    wire tick4k = x_rise && (div_q[2:0] == `RTC_DIV_4K_MAX) && !ctrl_q.stop;
    // second falls at 31 -> 32, so the first one after a halt needs 32 ticks
    wire tick1 = tick64 && (pre_q == `RTC_PRE_HALF) && !ctrl_q.stop;

    // halt holds the whole chain at zero; the crystal keeps running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 9'h000;
            pre_q <= 6'h00;
        end else if (ctrl_q.stop) begin
            div_q <= 9'h000;
            pre_q <= 6'h00;
        end else begin
            div_q <= x_rise ? 9'(div_q + 9'h001) : div_q;
            pre_q <= tick64 ? 6'(pre_q + 6'h01) : pre_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time counters

    logic [6:0] sec_q;
    logic [6:0] min_q;
    logic [5:0] hour_q;
    logic osf_q; // oscillator fail flag
    wire [7:0] sec_n = bcd_inc(sec_q, `RTC_BCD_59);
    wire [7:0] min_n = bcd_inc(min_q, `RTC_BCD_59);
    wire [7:0] hour_n = bcd_inc({1'b0, hour_q}, `RTC_BCD_23);
    wire min_step = tick1 && sec_n[7];
    wire hour_step = min_step && min_n[7];
    wire day_step = hour_step && hour_n[7];

    // bcd chain; a host write wins over a step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_q <= 7'h00;
            min_q <= 7'h00;
            hour_q <= 6'h00;
            day_carry_q <= 1'b0;
        end else begin
            sec_q <= w_sec ? rq.wdata[6:0] : (tick1 ? sec_n[6:0] : sec_q);
            min_q <= w_min ? rq.wdata[6:0] : (min_step ? min_n[6:0] : min_q);
            hour_q <= w_hr ? rq.wdata[5:0] : (hour_step ? hour_n[5:0] : hour_q);
            day_carry_q <= day_step;
        end
    end

    // watchdog on crystal edges; a stalled crystal sets the fail flag
    logic [31:0] osc_cnt_q;
    wire osc_fail = (osc_cnt_q >= 32'(OSC_FAIL_CYCLES));

    // fail flag resets to 1, a detected stall beats a host clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_q <= 32'h0;
            osf_q <= 1'b1;
        end else begin
            osc_cnt_q <= (x_rise || osc_fail) ? 32'h0 : 32'(osc_cnt_q + 32'h1);
            osf_q <= osc_fail || (w_sec ? rq.wdata[`RTC_B_TOP] : osf_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // countdown timer

    logic [7:0] tload_q; // software-loaded period n
    logic [7:0] tcnt_q; // current count
    logic tf_q;
    logic tf_d;
    logic src_tick;
    rtc_pkg::rtc_src_t src;
    assign src = rtc_pkg::rtc_src_t'(ctrl_q.td);

    always_comb begin
        unique case (src)
            rtc_pkg::SRC_4096: src_tick = tick4k;
            rtc_pkg::SRC_64: src_tick = tick64 && !ctrl_q.stop;
            rtc_pkg::SRC_1: src_tick = tick1;
            rtc_pkg::SRC_60: src_tick = min_step;
        endcase
    end

    // steps only while enabled; n of zero stops the timer
    wire tmr_step = ctrl_q.te && src_tick && (tload_q != 8'h00);
    wire tmr_end = tmr_step && (tcnt_q <= 8'h01);
    // write 0 clears, write 1 leaves it; a new period end wins
    wire tf_clr = w_c2 && !rq.wdata[`RTC_B_TF];
    // flag set at each period end
    assign tf_d = tmr_end || (tf_q && !tf_clr);

    // loading the period also restarts the count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tload_q <= 8'h00;
            tcnt_q <= 8'h00;
            tf_q <= 1'b0;
        end else begin
            tload_q <= w_tv ? rq.wdata : tload_q;
            tcnt_q <= w_tv ? rq.wdata : (tmr_end ? tload_q
                      : (tmr_step ? 8'(tcnt_q - 8'h01) : tcnt_q));
            tf_q <= tf_d;
        end
    end

    // low pulse width in crystal ticks; fast sources halve it for n of 1
    logic [9:0] pw_q;
    wire n_one = (tload_q == 8'h01);
    wire [9:0] pw_len = (src == rtc_pkg::SRC_4096) ? (n_one ? `RTC_PW_8192 : `RTC_PW_4096)
                      : (src == rtc_pkg::SRC_64) ? (n_one ? `RTC_PW_128 : `RTC_PW_64)
                      : `RTC_PW_64;
    wire [9:0] pw_d = (tmr_end && ctrl_q.tp) ? pw_len
                    : ((x_rise && pw_q != 10'h000) ? 10'(pw_q - 10'h001) : pw_q);

    // pulse length counter runs on the crystal, which a halt does not stop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pw_q <= 10'h000;
        end else begin
            pw_q <= pw_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm compare

    logic [7:0] alm_q [0:3]; // minute, hour, date, weekday with disable in bit 7
    logic match_q;
    logic af_q;
    wire [3:0] alm_hit;
    assign alm_hit[0] = alm_q[0][`RTC_B_TOP] || (alm_q[0][6:0] == min_q);
    assign alm_hit[1] = alm_q[1][`RTC_B_TOP] || (alm_q[1][5:0] == hour_q);
    assign alm_hit[2] = alm_q[2][`RTC_B_TOP] || (alm_q[2][5:0] == cal_date);
    assign alm_hit[3] = alm_q[3][`RTC_B_TOP] || (alm_q[3][2:0] == cal_weekday);
    wire any_en = !(alm_q[0][7] && alm_q[1][7] && alm_q[2][7] && alm_q[3][7]);
    wire match = any_en && (&alm_hit);
    // only a fresh match sets the flag again
    wire alm_rise = match && !match_q;
    // write 0 clears, write 1 leaves it; a fresh match wins
    wire af_d = alm_rise || (af_q && !(w_c2 && !rq.wdata[`RTC_B_AF]));

    // alarm registers reset with every field disabled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                alm_q[i] <= 8'h80;
            end
            match_q <= 1'b0;
            af_q <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_hit(rq, 8'(`RTC_A_ALM_MIN + i))) begin
                    alm_q[i] <= rq.wdata;
                end
            end
            match_q <= match;
            af_q <= af_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins

    // level mode follows the flag, pulse mode uses the counter
    wire tmr_irq = ctrl_q.countdown_irq_enable && (ctrl_q.tp ? (pw_d != 10'h000) : tf_d);
    // both enabled sources share the one pin
    wire int_act = tmr_irq || (ctrl_q.alarm_irq_enable && af_d);
    // rate select; 32768 Hz comes straight off the crystal
    wire sq_wave = (ctrl_q.rs == 2'h0) ? x_lvl_q : (ctrl_q.rs == 2'h1) ? div_q[4]
                 : (ctrl_q.rs == 2'h2) ? pre_q[0] : pre_q[5];

    // pins registered so they change together with the flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_n_o_q <= 1'b0;
            int_n_oe_q <= 1'b0;
            sq_o_q <= 1'b0;
            sq_oe_q <= 1'b0;
            por_override_permit_q <= 1'b1;
        end else begin
            int_n_o_q <= 1'b0;
            int_n_oe_q <= int_act;
            sq_o_q <= sq_wave;
            // float when disabled or used as test input
            sq_oe_q <= ctrl_d.square_out_enable && !ctrl_d.test;
            por_override_permit_q <= ctrl_d.por_override_permit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read

    logic [7:0] rd_mux;
    // unmapped and calendar addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        case (rq.addr)
            `RTC_A_CTRL1: rd_mux = {ctrl_q.test, 1'b0, ctrl_q.stop, 1'b0, ctrl_q.por_override_permit, 3'h0};
            `RTC_A_CTRL2: rd_mux = {3'h0, ctrl_q.tp, af_q, tf_q, ctrl_q.alarm_irq_enable, ctrl_q.countdown_irq_enable};
            `RTC_A_SEC: rd_mux = {osf_q, sec_q};
            `RTC_A_MIN: rd_mux = {1'b0, min_q};
            `RTC_A_HOUR: rd_mux = {2'h0, hour_q};
            `RTC_A_SQW: rd_mux = {ctrl_q.square_out_enable, 5'h00, ctrl_q.rs};
            `RTC_A_TCTRL: rd_mux = {ctrl_q.te, 5'h00, ctrl_q.td};
            `RTC_A_TVAL: rd_mux = tcnt_q;
            default: begin
                if (rq.addr >= `RTC_A_ALM_MIN && rq.addr <= `RTC_A_ALM_WDAY) begin
                    rd_mux = alm_q[2'(rq.addr - `RTC_A_ALM_MIN)];
                end
            end
        endcase
    end

    // read data held until the next read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (rq.rd) begin
            rd_data_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence pulse_start;
        tmr_end && ctrl_q.tp && ctrl_q.countdown_irq_enable;
    endsequence

    tf_set_a: assert property (tmr_end |=> tf_q)
        else $error("countdown flag not set at period end");
    tf_hold_a: assert property (tf_q && !tf_clr |=> tf_q)
        else $error("countdown flag lost without a clear");
    tmr_reload_a: assert property (tmr_end && !w_tv |=> tcnt_q == $past(tload_q))
        else $error("count did not reload after 01");
    tmr_idle_a: assert property (!ctrl_q.te && !w_tv && !w_tc
        |=> $stable(tcnt_q) && !tmr_end)
        else $error("disabled timer moved");
    pulse_pin_a: assert property (pulse_start |=> int_n_oe_q [*2])
        else $error("interrupt pulse not driven");
    irq_gate_a: assert property (!ctrl_q.countdown_irq_enable && !ctrl_q.alarm_irq_enable |=> !int_n_oe_q)
        else $error("interrupt driven while both sources disabled");
    sq_float_a: assert property (!ctrl_q.square_out_enable && !w_sqw |=> !sq_oe_q)
        else $error("square pin driven while disabled");
    stop_chain_a: assert property (ctrl_q.stop |=> div_q == 9'h000 && pre_q == 6'h00)
        else $error("divider chain ran while halted");
    sec_wrap_a: assert property (tick1 && sec_q == 7'h59 && !w_sec && !w_min
        |=> sec_q == 7'h00 && min_q != $past(min_q))
        else $error("seconds wrap did not carry");
    af_edge_a: assert property (alm_rise |=> af_q)
        else $error("alarm match did not set flag");

endmodule // rtc_core

// ---- rtc_host_model.sv ----
// host model that reaches the clock core through its byte-wide register port
module rtc_host_model (
    // clock
    input wire logic sys_clk,
    // register port towards the core
    output rtc_pkg::rtc_bus_req_t bus_req,
    input wire logic [7:0] rd_data_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // port idle from time zero, so no stray strobe during reset
    initial bus_req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // one access: strobe held across exactly one edge, data taken after it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge sys_clk);
        #2 bus_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        // release after the taking edge, once its updates have landed
        #2 bus_req = '0;
        q = rd_data_q;
    endtask

    // plain register write, read data thrown away
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // park unused timer
    // slowest source and timer off keeps the divider tap quiet
    task automatic park();
        wr(8'h0e, 8'h03);
    endtask
endmodule // rtc_host_model

// ---- testbench.sv ----
// self-checking bench of the clock core
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // design signals
    logic sys_clk, rst_n, xtal_i, xtal_run, sq_i, pv;
    rtc_pkg::rtc_bus_req_t bus_req;
    logic [7:0] rd_data_q, q;
    logic day_carry_q, int_n_o_q, int_n_oe_q, sq_o_q, sq_oe_q, por_q;
    // bookkeeping
    int fails, checked, cycles, carries, hi, lo, k, n;
    logic [31:0] seed;
    // reset table, 0x10 and 0x05 are unmapped
    logic [7:0] ra[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h05};
    logic [7:0] re[10] = '{8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 8'h03, 8'h00, 8'h00, 8'h00};
    // square cases: control 1, square control, crystal half periods per toggle
    logic [7:0] sc[3] = '{8'h08, 8'h08, 8'h28};
    logic [7:0] sr[3] = '{8'h80, 8'h81, 8'h80};
    int sh[3] = '{1, 32, 1};

    ////////////////////////////////////////////////////////////////////////////
    // watchdog shortened so a stopped crystal shows within a few hundred cycles
    rtc_core #(.OSC_FAIL_CYCLES(200)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
        .rd_data_q(rd_data_q), .xtal_i(xtal_i), .cal_date(6'h00), .cal_weekday(3'h0),
        .day_carry_q(day_carry_q), .int_n_o_q(int_n_o_q), .int_n_oe_q(int_n_oe_q), .sq_i(sq_i),
        .sq_o_q(sq_o_q), .sq_oe_q(sq_oe_q), .por_override_permit_q(por_q));
    rtc_host_model host (.sys_clk(sys_clk), .bus_req(bus_req), .rd_data_q(rd_data_q));

    // 40 mhz system clock
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // crystal sped up and out of phase, stands still when stopped
    initial begin
        xtal_i = 0;
        forever #97 if (xtal_run) xtal_i = ~xtal_i;
    end
    // hang guard and day carry counter
    always @(posedge sys_clk) begin
        cycles++;
        if (day_carry_q === 1'b1) carries++;
        if (cycles == 40000) begin
            fails++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // cycles spanned by c crystal periods
    function automatic int xc(input int c);
        return c * 194 / 25;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // timing figures carry crystal sampling jitter
    task automatic near(input int seen, input int exp, input int tol);
        check(8'((seen >= exp - tol) && (seen <= exp + tol)), 8'h01);
    endtask
    task automatic rd(input logic [7:0] a);
        host.acc(1'b0, a, 8'h00, q);
    endtask
    // bounded wait for the interrupt pin enable int_n_oe_q to reach v
    task automatic wt(input logic v, output int c);
        c = 0;
        while (int_n_oe_q !== v && c < 5000) begin
            @(posedge sys_clk);
            c++;
        end
    endtask
    // e rising edges on the square pin, 8 cycles apart
    task automatic ext(input int e);
        repeat (e) begin
            repeat (4) @(posedge sys_clk);
            #2 sq_i = 1;
            repeat (4) @(posedge sys_clk);
            #2 sq_i = 0;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, sq_i, cycles, fails, checked, carries} = '0;
        xtal_run = 1;
        seed = 45;
        repeat (20) @(posedge sys_clk);
        #2 rst_n = 1;
        // reset values, unmapped write must vanish
        host.wr(8'h10, 8'hff);
        check({7'h0, por_q}, 8'h01);
        check({7'h0, sq_oe_q}, 8'h01);
        for (int i = 0; i < 10; i++) begin
            rd(ra[i]);
            check(q, re[i]);
        end
        $display("test reset done");
        // level mode, random load
        seed = xs(seed);
        n = int'(seed % 32'd4) + 1;
        host.wr(8'h0e, 8'h80);
        host.wr(8'h0f, n[7:0]);
        host.wr(8'h01, 8'h01);
        wt(1'b1, k);
        rd(8'h01);
        check(q, 8'h05);
        host.wr(8'h01, 8'h05);
        repeat (3) @(posedge sys_clk);
        check({7'h0, int_n_oe_q}, 8'h01);
        host.park();
        host.wr(8'h01, 8'h01);
        rd(8'h01);
        check(q, 8'h01);
        check({7'h0, int_n_oe_q}, 8'h00);
        rd(8'h0f);
        hi = q;
        repeat (300) @(posedge sys_clk);
        rd(8'h0f);
        check(q, hi[7:0]);
        rd(8'h01);
        check(q, 8'h01);
        // flag without pin while the enable is off
        host.wr(8'h01, 8'h00);
        host.wr(8'h0e, 8'h80);
        hi = 0;
        repeat (300) begin
            @(posedge sys_clk);
            if (int_n_oe_q !== 1'b0) hi++;
        end
        check(hi[7:0], 8'h00);
        rd(8'h01);
        check(q, 8'h04);
        $display("test level done");
        // pulse mode, n of 1 and a random n above 1
        seed = xs(seed);
        for (int j = 0; j < 3; j++) begin
            n = (j == 1) ? int'(seed % 32'd3) + 2 : 1;
            // third pass moves the timer to the 64 hz source
            if (j == 2) host.wr(8'h0e, 8'h81);
            host.wr(8'h01, 8'h11);
            host.wr(8'h0f, n[7:0]);
            // let a pulse of the previous pass run out first
            wt(1'b0, k);
            wt(1'b1, k);
            wt(1'b0, hi);
            wt(1'b1, lo);
            near(hi, xc(j == 2 ? 256 : (n == 1 ? 4 : 8)), 10);
            near(hi + lo, xc((j == 2 ? 512 : 8) * n), 10);
            rd(8'h0f);
            check(8'(q >= 1 && q <= n), 8'h01);
        end
        host.park();
        host.wr(8'h01, 8'h00);
        $display("test pulse done");
        // square rates, then halted chain at crystal rate
        for (int j = 0; j < 3; j++) begin
            host.wr(8'h00, sc[j]);
            host.wr(8'h0d, sr[j]);
            hi = 0;
            pv = sq_o_q;
            repeat (2000) begin
                @(posedge sys_clk);
                if (sq_o_q !== pv) hi++;
                pv = sq_o_q;
            end
            near(hi, 2000 * 25 / (sh[j] * 97), 4);
        end
        host.wr(8'h0d, 8'h00);
        check({7'h0, sq_oe_q}, 8'h00);
        host.wr(8'h00, 8'h00);
        check({7'h0, por_q}, 8'h00);
        $display("test square done");
        // external tick mode with minute alarm on 00
        host.wr(8'h0d, 8'h80);
        host.wr(8'h00, 8'ha8);
        check({7'h0, sq_oe_q}, 8'h00);
        host.wr(8'h02, 8'h59);
        host.wr(8'h03, 8'h59);
        host.wr(8'h04, 8'h23);
        host.wr(8'h09, 8'h00);
        host.wr(8'h01, 8'h02);
        host.wr(8'h00, 8'h88);
        carries = 0;
        ext(32);
        rd(8'h02);
        check(q, 8'h00);
        rd(8'h03);
        check(q, 8'h00);
        rd(8'h04);
        check(q, 8'h00);
        check(carries[7:0], 8'h01);
        rd(8'h01);
        check(q, 8'h0a);
        check({7'h0, int_n_oe_q}, 8'h01);
        check({7'h0, int_n_o_q}, 8'h00);
        host.wr(8'h01, 8'h08);
        rd(8'h01);
        check({7'h0, int_n_oe_q}, 8'h00);
        host.wr(8'h01, 8'h02);
        rd(8'h01);
        check(q, 8'h02);
        ext(64);
        rd(8'h02);
        check(q, 8'h01);
        rd(8'h01);
        check(q, 8'h02);
        $display("test tick done");
        // crystal stops, fail flag must come back
        host.wr(8'h00, 8'h08);
        xtal_run = 0;
        repeat (300) @(posedge sys_clk);
        rd(8'h02);
        check(q & 8'h80, 8'h80);
        xtal_run = 1;
        $display("test osc done");
        finish_test();
    end
endmodule // testbench
